/* File: bench/fcvr_tb.sv */
// Self-checking bench for the current and voltage register bank
`timescale 1ns/1ps
`include "fcvr_regs.svh"
`define CHK(n, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("unexpected %s exp %h got %h", n, e, g); \
  end \
end
module testbench;
  import fcvr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_p = 1'b0;
  fcvr_addr_t addr = '0;
  fcvr_byte_t wdata = '0;
  fcvr_byte_t rdata, qf, df, exp_v;
  fcvr_word_t iq = '0, ib = '0, vb = '0, ud = '0, uq = '0;
  fcvr_word_t dv, qv;
  fcvr_word_t cd = '0, cq = '0;
  fcvr_byte_t exp_q[$];
  int num_errors = 0;
  int tests_run = 0;
  int seed = 43931;
  always #20 ref_clk = ~ref_clk;
  fcvr_regs i_dut (.REF_CLK(ref_clk), .RST_B(rst_b), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .Q_AXIS_CURRENT(iq), .BETA_AXIS_CURRENT(ib),
    .BETA_OUTPUT_VOLTAGE(vb), .D_CONTROLLER_OUTPUT(ud),
    .Q_CONTROLLER_OUTPUT(uq), .Q_CURRENT_FILTER_COEFF(qf),
    .D_CURRENT_FILTER_COEFF(df), .D_VOLTAGE_OUT(dv), .Q_VOLTAGE_OUT(qv));
  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_p) begin
      exp_v = exp_q.pop_front();
      `CHK("read data", exp_v, rdata)
    end
    rd_p <= rd;
  end
  // One bus cycle; strobes are never both high
  task automatic bus(input logic w, input logic r, input fcvr_addr_t a,
                     input fcvr_byte_t d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
  endtask : bus
  task automatic rd_b(input fcvr_addr_t a, input fcvr_byte_t e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd_b
  // Back-to-back reads of every readout, then write-only and unmapped
  task automatic check_reads();
    logic [47:0] all;
    all = {iq, ib, vb};
    for (int i = 0; i < 6; i++) begin
      rd_b(fcvr_addr_t'(16'h40be + i), all[47 - 8 * i -: 8]);
    end
    rd_b(16'h40c4, 8'h00);
    rd_b(16'h40c5, 8'h00);
    rd_b(16'h1234, 8'h00);
    bus(1'b0, 1'b0, 16'h0000, 8'h00);
    bus(1'b0, 1'b0, 16'h0000, 8'h00);
  endtask : check_reads
  task automatic check_outs(input fcvr_byte_t eq, input fcvr_byte_t ed);
    `CHK("q coeff", eq, qf)
    `CHK("d coeff", ed, df)
    `CHK("d volt", fcvr_word_t'(ud + cd), dv)
    `CHK("q volt", fcvr_word_t'(uq + cq), qv)
  endtask : check_outs
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    check_outs(8'hff, 8'hff);
    check_reads();
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      iq <= fcvr_word_t'($random(seed));
      ib <= fcvr_word_t'($random(seed));
      vb <= fcvr_word_t'($random(seed));
      ud <= fcvr_word_t'($random(seed));
      uq <= fcvr_word_t'($random(seed));
      cd = fcvr_word_t'($random(seed));
      cq = fcvr_word_t'($random(seed));
      // Shared and write-only addresses: writes land in the write-only side
      bus(1'b1, 1'b0, 16'h40c2, cd[15:8]);
      bus(1'b1, 1'b0, 16'h40c3, cd[7:0]);
      bus(1'b1, 1'b0, 16'h40c4, cq[15:8]);
      bus(1'b1, 1'b0, 16'h40c5, cq[7:0]);
      bus(1'b1, 1'b0, 16'h40c0, cq[7:0]);
      bus(1'b1, 1'b0, 16'h40c1, cd[7:0]);
      // Writes to a readout or an unmapped place must change nothing
      bus(1'b1, 1'b0, 16'h40be, 8'h5a);
      bus(1'b1, 1'b0, 16'h1234, 8'ha5);
      bus(1'b0, 1'b0, 16'h0000, 8'h00);
      check_outs(cq[7:0], cd[7:0]);
      check_reads();
      $display("test %0d done", k);
    end
    print_verdict();
  end
  // Whole run needs about 94 cycles
  initial begin
    repeat (2000) @(posedge ref_clk);
    num_errors++;
    print_verdict();
  end
endmodule : testbench

/* File: include/fcvr_pkg.sv */
// Types shared by the current and voltage register bank
package fcvr_pkg;
  typedef logic [7:0] fcvr_byte_t;
  typedef logic signed [15:0] fcvr_word_t;
  typedef logic [15:0] fcvr_addr_t;
endpackage : fcvr_pkg

/* File: include/fcvr_regs.svh */
// Register offsets, reset values and widths of the current and voltage bank
// Contract
// RQ1: q-axis current reads as signed 16 bits in two bytes, reset zero.
// RQ2: beta-axis current reads as signed 16 bits in two bytes, reset zero.
// RQ3: Write at beta-current high loads q filter coefficient; resets to ff.
// RQ4: Write at beta-current low loads d filter coefficient; resets to ff.
// RQ5: beta output voltage reads as signed 16 bits in two bytes, reset 0.
// RQ6: d compensation written at beta voltage addresses; added to d output.
// RQ7: Write-only q compensation, reset zero; added to q output, passed on.
// RQ8: d controller output is signed 16 bits, the d compensation sum operand.
// RQ9: q controller output is signed 16 bits, the q compensation sum operand.
// RQ10: Bits 15..8 sit at the lower byte address, bits 7..0 at the next.
`ifndef FCVR_REGS_SVH
`define FCVR_REGS_SVH
`define FCVR_ADDR_W 16
`define FCVR_DATA_W 8
`define FCVR_WORD_W 16
`define FCVR_Q_CURRENT_HIGH 16'h40be
`define FCVR_Q_CURRENT_LOW 16'h40bf
`define FCVR_BETA_CURRENT_HIGH 16'h40c0
`define FCVR_BETA_CURRENT_LOW 16'h40c1
`define FCVR_BETA_VOLTAGE_HIGH 16'h40c2
`define FCVR_BETA_VOLTAGE_LOW 16'h40c3
`define FCVR_Q_VOLTAGE_COMP_HIGH 16'h40c4
`define FCVR_Q_VOLTAGE_COMP_LOW 16'h40c5
`define FCVR_COEFF_RESET 8'hff
`define FCVR_BYTE_RESET 8'h00
`define FCVR_WORD_RESET 16'h0000
`endif

/* File: rtl/fcvr_regs.sv */
// Register bank for q/beta current, beta voltage, filters and compensation
`timescale 1ns/1ps
`include "fcvr_regs.svh"
module fcvr_regs (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // Register port
  input wire fcvr_pkg::fcvr_addr_t ADDR,
  input wire fcvr_pkg::fcvr_byte_t WDATA,
  input wire logic WR,
  input wire logic RD,
  output fcvr_pkg::fcvr_byte_t RDATA,
  // Values from the control engine
  input wire fcvr_pkg::fcvr_word_t Q_AXIS_CURRENT,
  input wire fcvr_pkg::fcvr_word_t BETA_AXIS_CURRENT,
  input wire fcvr_pkg::fcvr_word_t BETA_OUTPUT_VOLTAGE,
  input wire fcvr_pkg::fcvr_word_t D_CONTROLLER_OUTPUT,
  input wire fcvr_pkg::fcvr_word_t Q_CONTROLLER_OUTPUT,
  // Values to the engine and next stage
  output fcvr_pkg::fcvr_byte_t Q_CURRENT_FILTER_COEFF,
  output fcvr_pkg::fcvr_byte_t D_CURRENT_FILTER_COEFF,
  output fcvr_pkg::fcvr_word_t D_VOLTAGE_OUT,
  output fcvr_pkg::fcvr_word_t Q_VOLTAGE_OUT
);
  import fcvr_pkg::*;

  // Upper or lower byte of a word by address parity
  function automatic fcvr_byte_t fcvr_pick(input fcvr_word_t w,
                                           input logic low);
    fcvr_pick = low ? w[7:0] : w[15:8]; // RQ10
  endfunction : fcvr_pick

  // Plain sum wraps; the engine downstream owns any saturation
  function automatic fcvr_word_t fcvr_add(input fcvr_word_t a,
                                          input fcvr_word_t b);
    fcvr_add = fcvr_word_t'(a + b);
  endfunction : fcvr_add

  // Engine values sampled each cycle so reads see a registered copy
  fcvr_word_t iq_r, iq_nxt;
  fcvr_word_t ibet_r, ibet_nxt;
  fcvr_word_t vbet_r, vbet_nxt;
  fcvr_byte_t qcoef_r, qcoef_nxt;
  fcvr_byte_t dcoef_r, dcoef_nxt;
  fcvr_word_t dcomp_r, dcomp_nxt;
  fcvr_word_t qcomp_r, qcomp_nxt;
  fcvr_byte_t rdata_r, rdata_nxt;
  fcvr_word_t dout_r, dout_nxt;
  fcvr_word_t qout_r, qout_nxt;

  always_comb begin
    iq_nxt = Q_AXIS_CURRENT; // RQ1
    ibet_nxt = BETA_AXIS_CURRENT; // RQ2
    vbet_nxt = BETA_OUTPUT_VOLTAGE; // RQ5
    qcoef_nxt = qcoef_r;
    dcoef_nxt = dcoef_r;
    dcomp_nxt = dcomp_r;
    qcomp_nxt = qcomp_r;
    // Shared addresses: writes land in the write-only copy, reads never do
    if (WR) begin
      if (ADDR == `FCVR_BETA_CURRENT_HIGH) begin
        qcoef_nxt = WDATA; // RQ3
      end else if (ADDR == `FCVR_BETA_CURRENT_LOW) begin
        dcoef_nxt = WDATA; // RQ4
      end else if (ADDR == `FCVR_BETA_VOLTAGE_HIGH) begin
        dcomp_nxt = {WDATA, dcomp_r[7:0]}; // RQ6 RQ10
      end else if (ADDR == `FCVR_BETA_VOLTAGE_LOW) begin
        dcomp_nxt = {dcomp_r[15:8], WDATA}; // RQ6 RQ10
      end else if (ADDR == `FCVR_Q_VOLTAGE_COMP_HIGH) begin
        qcomp_nxt = {WDATA, qcomp_r[7:0]}; // RQ7 RQ10
      end else if (ADDR == `FCVR_Q_VOLTAGE_COMP_LOW) begin
        qcomp_nxt = {qcomp_r[15:8], WDATA}; // RQ7 RQ10
      end
    end
  end

  // Read answers one cycle later; unmapped and write-only read as zero
  always_comb begin
    rdata_nxt = `FCVR_BYTE_RESET;
    if (RD) begin
      if (ADDR == `FCVR_Q_CURRENT_HIGH || ADDR == `FCVR_Q_CURRENT_LOW) begin
        rdata_nxt = fcvr_pick(iq_r, ADDR[0]); // RQ1
      end else if (ADDR == `FCVR_BETA_CURRENT_HIGH ||
                   ADDR == `FCVR_BETA_CURRENT_LOW) begin
        rdata_nxt = fcvr_pick(ibet_r, ADDR[0]); // RQ2
      end else if (ADDR == `FCVR_BETA_VOLTAGE_HIGH ||
                   ADDR == `FCVR_BETA_VOLTAGE_LOW) begin
        rdata_nxt = fcvr_pick(vbet_r, ADDR[0]); // RQ5
      end
    end
  end

  always_comb begin
    dout_nxt = fcvr_add(D_CONTROLLER_OUTPUT, dcomp_r); // RQ6 RQ8
    qout_nxt = fcvr_add(Q_CONTROLLER_OUTPUT, qcomp_r); // RQ7 RQ9
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      iq_r <= `FCVR_WORD_RESET;
      ibet_r <= `FCVR_WORD_RESET;
      vbet_r <= `FCVR_WORD_RESET;
      qcoef_r <= `FCVR_COEFF_RESET;
      dcoef_r <= `FCVR_COEFF_RESET;
      dcomp_r <= `FCVR_WORD_RESET;
      qcomp_r <= `FCVR_WORD_RESET;
      rdata_r <= `FCVR_BYTE_RESET;
      dout_r <= `FCVR_WORD_RESET;
      qout_r <= `FCVR_WORD_RESET;
    end else begin
      iq_r <= iq_nxt;
      ibet_r <= ibet_nxt;
      vbet_r <= vbet_nxt;
      qcoef_r <= qcoef_nxt;
      dcoef_r <= dcoef_nxt;
      dcomp_r <= dcomp_nxt;
      qcomp_r <= qcomp_nxt;
      rdata_r <= rdata_nxt;
      dout_r <= dout_nxt;
      qout_r <= qout_nxt;
    end
  end

  assign RDATA = rdata_r;
  assign Q_CURRENT_FILTER_COEFF = qcoef_r;
  assign D_CURRENT_FILTER_COEFF = dcoef_r;
  assign D_VOLTAGE_OUT = dout_r;
  assign Q_VOLTAGE_OUT = qout_r;

  property p_iq_read;
    @(posedge REF_CLK) disable iff (!RST_B)
    RD && ADDR == `FCVR_Q_CURRENT_HIGH ##1 1 |->
      RDATA == fcvr_byte_t'($past(Q_AXIS_CURRENT, 2) >>> 8);
  endproperty
  a_iq_read: assert property (p_iq_read) // RQ1
    else $error("q current high byte wrong");

  property p_ibet_read;
    @(posedge REF_CLK) disable iff (!RST_B)
    RD && ADDR == `FCVR_BETA_CURRENT_LOW |=>
      RDATA == $past(ibet_r[7:0]);
  endproperty
  a_ibet_read: assert property (p_ibet_read) // RQ2
    else $error("beta current low byte wrong");

  property p_qcoef;
    @(posedge REF_CLK) disable iff (!RST_B)
    WR && ADDR == `FCVR_BETA_CURRENT_HIGH |=>
      Q_CURRENT_FILTER_COEFF == $past(WDATA) ##1 1;
  endproperty
  a_qcoef: assert property (p_qcoef) // RQ3
    else $error("q filter coefficient not loaded");

  property p_dcoef;
    @(posedge REF_CLK) disable iff (!RST_B)
    WR && ADDR == `FCVR_BETA_CURRENT_LOW |=>
      D_CURRENT_FILTER_COEFF == $past(WDATA);
  endproperty
  a_dcoef: assert property (p_dcoef) // RQ4
    else $error("d filter coefficient not loaded");

  property p_vbet_read;
    @(posedge REF_CLK) disable iff (!RST_B)
    RD && ADDR == `FCVR_BETA_VOLTAGE_HIGH |=>
      RDATA == $past(vbet_r[15:8]);
  endproperty
  a_vbet_read: assert property (p_vbet_read) // RQ5
    else $error("beta voltage high byte wrong");

  property p_dsum;
    @(posedge REF_CLK) disable iff (!RST_B)
    !WR ##1 1 |=> D_VOLTAGE_OUT ==
      fcvr_word_t'($past(D_CONTROLLER_OUTPUT) + $past(dcomp_r));
  endproperty
  a_dsum: assert property (p_dsum) // RQ6
    else $error("d output sum wrong");

  property p_qsum;
    @(posedge REF_CLK) disable iff (!RST_B)
    1 |=> Q_VOLTAGE_OUT ==
      fcvr_word_t'($past(Q_CONTROLLER_OUTPUT) + $past(qcomp_r));
  endproperty
  a_qsum: assert property (p_qsum) // RQ7
    else $error("q output sum wrong");

  property p_dout_zero_comp;
    @(posedge REF_CLK) disable iff (!RST_B)
    dcomp_r == `FCVR_WORD_RESET |=>
      D_VOLTAGE_OUT == $past(D_CONTROLLER_OUTPUT);
  endproperty
  a_dout_zero_comp: assert property (p_dout_zero_comp) // RQ8
    else $error("d output not passed through");

  property p_qcomp_order;
    @(posedge REF_CLK) disable iff (!RST_B)
    WR && ADDR == `FCVR_Q_VOLTAGE_COMP_HIGH |=>
      qcomp_r[15:8] == $past(WDATA) && qcomp_r[7:0] == $past(qcomp_r[7:0]);
  endproperty
  a_qcomp_order: assert property (p_qcomp_order) // RQ10
    else $error("q compensation byte order wrong");

  property p_wo_read_zero;
    @(posedge REF_CLK) disable iff (!RST_B)
    RD && ADDR == `FCVR_Q_VOLTAGE_COMP_LOW |=> RDATA == `FCVR_BYTE_RESET;
  endproperty
  a_wo_read_zero: assert property (p_wo_read_zero) // RQ7
    else $error("write-only register read nonzero");

  // Read data stand for exactly one cycle and are zero otherwise
  property p_rdata_idle;
    @(posedge REF_CLK) disable iff (!RST_B)
    !RD |=> RDATA == `FCVR_BYTE_RESET;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // RQ10
    else $error("read data outside read cycle");

  property p_iq_low;
    @(posedge REF_CLK) disable iff (!RST_B)
    RD && ADDR == `FCVR_Q_CURRENT_LOW |=> RDATA == $past(iq_r[7:0]);
  endproperty
  a_iq_low: assert property (p_iq_low) // RQ1
    else $error("q current low byte wrong");

  property p_ibet_high;
    @(posedge REF_CLK) disable iff (!RST_B)
    RD && ADDR == `FCVR_BETA_CURRENT_HIGH |=> RDATA == $past(ibet_r[15:8]);
  endproperty
  a_ibet_high: assert property (p_ibet_high) // RQ2
    else $error("beta current high byte wrong");

  property p_vbet_low;
    @(posedge REF_CLK) disable iff (!RST_B)
    RD && ADDR == `FCVR_BETA_VOLTAGE_LOW |=> RDATA == $past(vbet_r[7:0]);
  endproperty
  a_vbet_low: assert property (p_vbet_low) // RQ5
    else $error("beta voltage low byte wrong");

  // Snapshots follow the engine with one register of delay
  property p_iq_track;
    @(posedge REF_CLK) disable iff (!RST_B)
    1 |=> iq_r == $past(Q_AXIS_CURRENT);
  endproperty
  a_iq_track: assert property (p_iq_track) // RQ1
    else $error("q current snapshot stale");

  property p_ibet_track;
    @(posedge REF_CLK) disable iff (!RST_B)
    1 |=> ibet_r == $past(BETA_AXIS_CURRENT);
  endproperty
  a_ibet_track: assert property (p_ibet_track) // RQ2
    else $error("beta current snapshot stale");

  property p_vbet_track;
    @(posedge REF_CLK) disable iff (!RST_B)
    1 |=> vbet_r == $past(BETA_OUTPUT_VOLTAGE);
  endproperty
  a_vbet_track: assert property (p_vbet_track) // RQ5
    else $error("beta voltage snapshot stale");

  property p_qcoef_hold;
    @(posedge REF_CLK) disable iff (!RST_B)
    !(WR && ADDR == `FCVR_BETA_CURRENT_HIGH) |=>
      $stable(Q_CURRENT_FILTER_COEFF);
  endproperty
  a_qcoef_hold: assert property (p_qcoef_hold) // RQ3
    else $error("q filter coefficient changed unasked");

  property p_dcoef_hold;
    @(posedge REF_CLK) disable iff (!RST_B)
    !(WR && ADDR == `FCVR_BETA_CURRENT_LOW) |=>
      $stable(D_CURRENT_FILTER_COEFF);
  endproperty
  a_dcoef_hold: assert property (p_dcoef_hold) // RQ4
    else $error("d filter coefficient changed unasked");

  // Each byte write lands at once; no pairing latch between halves
  property p_dcomp_high;
    @(posedge REF_CLK) disable iff (!RST_B)
    WR && ADDR == `FCVR_BETA_VOLTAGE_HIGH |=>
      dcomp_r[15:8] == $past(WDATA) && dcomp_r[7:0] == $past(dcomp_r[7:0]);
  endproperty
  a_dcomp_high: assert property (p_dcomp_high) // RQ6
    else $error("d compensation high byte not loaded");

  property p_dcomp_low;
    @(posedge REF_CLK) disable iff (!RST_B)
    WR && ADDR == `FCVR_BETA_VOLTAGE_LOW |=>
      dcomp_r[7:0] == $past(WDATA) && dcomp_r[15:8] == $past(dcomp_r[15:8]);
  endproperty
  a_dcomp_low: assert property (p_dcomp_low) // RQ6
    else $error("d compensation low byte not loaded");

  property p_qcomp_low;
    @(posedge REF_CLK) disable iff (!RST_B)
    WR && ADDR == `FCVR_Q_VOLTAGE_COMP_LOW |=>
      qcomp_r[7:0] == $past(WDATA) && qcomp_r[15:8] == $past(qcomp_r[15:8]);
  endproperty
  a_qcomp_low: assert property (p_qcomp_low) // RQ7
    else $error("q compensation low byte not loaded");

  property p_dcomp_hold;
    @(posedge REF_CLK) disable iff (!RST_B)
    !(WR && (ADDR == `FCVR_BETA_VOLTAGE_HIGH ||
             ADDR == `FCVR_BETA_VOLTAGE_LOW)) |=> $stable(dcomp_r);
  endproperty
  a_dcomp_hold: assert property (p_dcomp_hold) // RQ6
    else $error("d compensation changed unasked");

  property p_qcomp_hold;
    @(posedge REF_CLK) disable iff (!RST_B)
    !(WR && (ADDR == `FCVR_Q_VOLTAGE_COMP_HIGH ||
             ADDR == `FCVR_Q_VOLTAGE_COMP_LOW)) |=> $stable(qcomp_r);
  endproperty
  a_qcomp_hold: assert property (p_qcomp_hold) // RQ7
    else $error("q compensation changed unasked");

  property p_qout_zero_comp;
    @(posedge REF_CLK) disable iff (!RST_B)
    qcomp_r == `FCVR_WORD_RESET |=>
      Q_VOLTAGE_OUT == $past(Q_CONTROLLER_OUTPUT);
  endproperty
  a_qout_zero_comp: assert property (p_qout_zero_comp) // RQ9
    else $error("q output not passed through");

  // A read at a shared address must never disturb its write-only twin
  property p_shared_read;
    @(posedge REF_CLK) disable iff (!RST_B)
    RD && !WR && ADDR == `FCVR_BETA_CURRENT_HIGH |=>
      $stable(Q_CURRENT_FILTER_COEFF);
  endproperty
  a_shared_read: assert property (p_shared_read) // RQ3
    else $error("read at shared address changed coefficient");

  // Writes to a readout are dropped; nothing writable moves
  property p_ro_write;
    @(posedge REF_CLK) disable iff (!RST_B)
    WR && ADDR == `FCVR_Q_CURRENT_HIGH |=>
      $stable(qcoef_r) && $stable(dcoef_r) &&
      $stable(dcomp_r) && $stable(qcomp_r);
  endproperty
  a_ro_write: assert property (p_ro_write) // RQ1
    else $error("write to readout changed a register");

  property p_unmapped_read;
    @(posedge REF_CLK) disable iff (!RST_B)
    RD && ADDR < `FCVR_Q_CURRENT_HIGH |=> RDATA == `FCVR_BYTE_RESET;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) // RQ10
    else $error("unmapped read nonzero");
endmodule : fcvr_regs
